// *** src/qdrlc_pkg.sv ***
// Constants, types and helpers shared by the queued-read and log-read command block
package qdrlc_pkg;
    localparam int AW = 8;
    // APB byte offsets
    localparam logic [7:0] OFF_DATA  = 8'h00;
    localparam logic [7:0] OFF_FEAT  = 8'h04;
    localparam logic [7:0] OFF_SCNT  = 8'h08;
    localparam logic [7:0] OFF_SNUM  = 8'h0C;
    localparam logic [7:0] OFF_CYLL  = 8'h10;
    localparam logic [7:0] OFF_CYLH  = 8'h14;
    localparam logic [7:0] OFF_DHEAD = 8'h18;
    localparam logic [7:0] OFF_CMD   = 8'h1C;
    localparam logic [7:0] OFF_DCTL  = 8'h20;
    localparam logic [7:0] OFF_CTRL  = 8'h24;
    localparam logic [7:0] OFF_STATE = 8'h28;
    // Command codes
    localparam logic [7:0] CMD_RDQ     = 8'hC7;
    localparam logic [7:0] CMD_RDQ_EXT = 8'h26;
    localparam logic [7:0] CMD_RD_LOG  = 8'h2F;
    localparam logic [7:0] CMD_SERVICE = 8'hA2;
    // Bit positions and control reset value
    localparam int ST_BSY  = 7;
    localparam int ST_RDY  = 6;
    localparam int ST_SRV  = 4;
    localparam int ST_DRQ  = 3;
    localparam int ST_ERR  = 0;
    localparam int ER_UNC  = 6;
    localparam int ER_ABT  = 2;
    localparam int SC_REL  = 2;
    localparam int SC_IO   = 1;
    localparam int SC_CD   = 0;
    localparam int DCTL_HOB = 7;
    localparam int CT_SMART   = 0;
    localparam int CT_ERRLOG  = 1;
    localparam int CT_SLFTEST = 2;
    localparam logic [7:0] CTRL_RESET = 8'h07;
    // Log addresses and sizes
    localparam logic [7:0]  LOG_DIR      = 8'h00;
    localparam logic [7:0]  LOG_EXT_ERR  = 8'h03;
    localparam logic [7:0]  LOG_SLFTEST  = 8'h06;
    localparam logic [7:0]  LOG_EXT_SLFT = 8'h07;
    localparam logic [7:0]  LOG_HOST_LO  = 8'h80;
    localparam logic [7:0]  LOG_HOST_HI  = 8'h9F;
    localparam logic [16:0] LOG_DIR_SECT  = 17'h00001;
    localparam logic [16:0] LOG_HOST_SECT = 17'h00010;
    // Sector counts and last word index
    localparam logic [16:0] SECT_MAX8  = 17'h00100;
    localparam logic [16:0] SECT_MAX16 = 17'h10000;
    localparam logic [7:0]  WORD_LAST  = 8'hFF;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_REL  = 4'b0010,
        ST_XFER = 4'b0100,
        ST_LOG  = 4'b1000
    } qdrlc_state_t;

    typedef enum logic [1:0] {
        K_NONE = 2'b00,
        K_RDQ  = 2'b01,
        K_RDQX = 2'b10,
        K_LOG  = 2'b11
    } qdrlc_kind_t;

    // Zero count means the largest transfer of that width
    function automatic logic [16:0] qdrlc_sectors(input logic [15:0] raw, input logic wide);
        if (raw != 16'h0000)
            return {1'b0, raw};
        return wide ? SECT_MAX16 : SECT_MAX8;
    endfunction

    function automatic logic [7:0] qdrlc_sc_report(input logic [4:0] tag, input logic release_flag);
        return {tag, release_flag, ~release_flag, ~release_flag};
    endfunction

    function automatic logic [7:0] qdrlc_pick(input logic high_order_readback, input logic [7:0] cur,
                                              input logic [7:0] prev);
        return high_order_readback ? prev : cur;
    endfunction
endpackage

// *** src/qdrlc_log_check.sv ***
// Log address decode and parameter check for the extended log read
module qdrlc_log_check #(
    parameter logic [16:0] EXT_ERR_SECT  = 17'h00001,
    parameter logic [16:0] EXT_SLFT_SECT = 17'h00001
) (
    input  wire logic [7:0]  log_addr,
    input  wire logic [15:0] first_sector,
    input  wire logic [15:0] count,
    input  wire logic [7:0]  ctrl,
    output logic             abort
);
    import qdrlc_pkg::*;
    logic [16:0] size;
    logic        enabled;
    logic [16:0] last;

    always_comb begin
        size    = 17'h00000;
        enabled = 1'b0;
        if (log_addr == LOG_DIR) begin
            size    = LOG_DIR_SECT;
            enabled = 1'b1;
        end else if (log_addr == LOG_EXT_ERR) begin
            size    = EXT_ERR_SECT;
            enabled = ctrl[CT_ERRLOG];
        end else if (log_addr == LOG_EXT_SLFT) begin
            // Entries of both address widths are supplied by the back end
            size    = EXT_SLFT_SECT;
            enabled = ctrl[CT_SLFTEST];
        end else if (log_addr >= LOG_HOST_LO && log_addr <= LOG_HOST_HI) begin
            size    = LOG_HOST_SECT;
            enabled = ctrl[CT_SMART];
        end
        last  = {1'b0, first_sector} + {1'b0, count};
        // 06h is never reachable this way, even with self-test enabled
        abort = (log_addr == LOG_SLFTEST) || !enabled || count == 16'h0000
              || last > size;
    end
endmodule

// *** src/qdrlc_cmd.sv ***
// Task-file command interpreter for queued DMA reads and extended log read
import qdrlc_pkg::*;

module qdrlc_cmd #(
    parameter logic [16:0] EXT_ERR_SECT  = 17'h00001,
    parameter logic [16:0] EXT_SLFT_SECT = 17'h00001
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [qdrlc_pkg::AW-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       intrq,
    output logic                       dmarq,
    input  wire logic                  dma_ack,
    output logic [15:0]                dma_data,
    input  wire logic                  be_data_avail,
    input  wire logic                  be_word_valid,
    input  wire logic [15:0]           be_word,
    output logic                       be_word_ready,
    input  wire logic                  be_error,
    input  wire logic [47:0]           be_err_lba,
    output logic                       cmd_start,
    output qdrlc_pkg::qdrlc_kind_t     cmd_kind,
    output logic [47:0]                cmd_lba,
    output logic [16:0]                cmd_sectors,
    output logic [4:0]                 cmd_tag
);
    import qdrlc_pkg::*;

    typedef struct packed {
        qdrlc_state_t state;
        qdrlc_kind_t  kind;
        logic [7:0]   feat_cur;
        logic [7:0]   feat_prev;
        logic [7:0]   sc_cur;
        logic [7:0]   sc_prev;
        logic [7:0]   sn_cur;
        logic [7:0]   sn_prev;
        logic [7:0]   cl_cur;
        logic [7:0]   cl_prev;
        logic [7:0]   ch_cur;
        logic [7:0]   ch_prev;
        logic [7:0]   dh;
        logic         high_order_readback;
        logic [7:0]   err;
        logic         errf;
        logic         service_pending;
        logic [7:0]   ctrl;
        logic         intrq;
        logic [4:0]   tag;
        logic [24:0]  words_left;
        logic [7:0]   word_idx;
        logic [15:0]  word;
        logic         full;
        logic         dmarq;
        logic         word_ready;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
        logic         cmd_start;
        logic [47:0]  cmd_lba;
        logic [16:0]  cmd_sectors;
    } qdrlc_regs_t;

    localparam qdrlc_regs_t S_RESET = '{state: ST_IDLE, kind: K_NONE, ctrl: CTRL_RESET,
                                        default: '0};

    qdrlc_regs_t s_q;
    qdrlc_regs_t s_d;
    logic        log_abort;
    logic        setup;
    logic        acc;
    logic        mapped;
    logic        wr;
    logic        rd;
    logic        drain;
    logic [7:0]  status;

    qdrlc_log_check #(
        .EXT_ERR_SECT  (EXT_ERR_SECT),
        .EXT_SLFT_SECT (EXT_SLFT_SECT)
    ) u_log_check (
        .log_addr     (s_q.sn_cur),
        .first_sector ({s_q.cl_prev, s_q.cl_cur}),
        .count        ({s_q.sn_prev, s_q.sc_cur}),
        .ctrl         (s_q.ctrl),
        .abort        (log_abort)
    );

    always_comb begin
        s_d = s_q;
        s_d.cmd_start = 1'b0;
        setup  = psel && !penable;
        acc    = psel && penable && s_q.pready;
        mapped = paddr <= OFF_STATE && paddr[1:0] == 2'b00;
        wr     = acc && pwrite && mapped;
        rd     = acc && !pwrite && mapped;
        status = 8'h00;
        status[ST_RDY] = 1'b1;
        status[ST_BSY] = s_q.state == ST_LOG && !s_q.full;
        status[ST_SRV] = s_q.service_pending;
        status[ST_DRQ] = s_q.state == ST_XFER || (s_q.state == ST_LOG && s_q.full);
        status[ST_ERR] = s_q.errf;

        // Read data is captured in the setup phase, so every access has zero wait states
        s_d.pready  = setup;
        s_d.pslverr = setup && !mapped;
        if (setup) begin
            s_d.prdata = 32'h0000_0000;
            case (paddr)
                OFF_DATA:  s_d.prdata[15:0] = s_q.full ? s_q.word : 16'h0000;
                OFF_FEAT:  s_d.prdata[7:0] = s_q.err;
                OFF_SCNT:  s_d.prdata[7:0] = qdrlc_pick(s_q.high_order_readback, s_q.sc_cur, s_q.sc_prev);
                OFF_SNUM:  s_d.prdata[7:0] = qdrlc_pick(s_q.high_order_readback, s_q.sn_cur, s_q.sn_prev);
                OFF_CYLL:  s_d.prdata[7:0] = qdrlc_pick(s_q.high_order_readback, s_q.cl_cur, s_q.cl_prev);
                OFF_CYLH:  s_d.prdata[7:0] = qdrlc_pick(s_q.high_order_readback, s_q.ch_cur, s_q.ch_prev);
                OFF_DHEAD: s_d.prdata[7:0] = s_q.dh;
                OFF_CMD:   s_d.prdata[7:0] = status;
                OFF_DCTL:  s_d.prdata[7:0] = status;
                OFF_CTRL:  s_d.prdata[7:0] = s_q.ctrl;
                OFF_STATE: s_d.prdata[3:0] = s_q.state;
                default:   s_d.prdata = 32'h0000_0000;
            endcase
        end

        // Reading status acknowledges the interrupt; the alternate copy does not
        if (rd && paddr == OFF_CMD)
            s_d.intrq = 1'b0;

        if (wr) begin
            case (paddr)
                OFF_FEAT: begin
                    s_d.feat_prev = s_q.feat_cur;
                    s_d.feat_cur  = pwdata[7:0];
                end
                OFF_SCNT: begin
                    s_d.sc_prev = s_q.sc_cur;
                    s_d.sc_cur  = pwdata[7:0];
                end
                OFF_SNUM: begin
                    s_d.sn_prev = s_q.sn_cur;
                    s_d.sn_cur  = pwdata[7:0];
                end
                OFF_CYLL: begin
                    s_d.cl_prev = s_q.cl_cur;
                    s_d.cl_cur  = pwdata[7:0];
                end
                OFF_CYLH: begin
                    s_d.ch_prev = s_q.ch_cur;
                    s_d.ch_cur  = pwdata[7:0];
                end
                OFF_DHEAD: s_d.dh = pwdata[7:0];
                OFF_DCTL:  s_d.high_order_readback = pwdata[DCTL_HOB];
                OFF_CTRL:  s_d.ctrl = pwdata[7:0];
                OFF_CMD: begin
                    s_d.err  = 8'h00;
                    s_d.errf = 1'b0;
                    if (s_q.state == ST_IDLE && pwdata[7:0] == CMD_RDQ) begin
                        s_d.kind        = K_RDQ;
                        s_d.tag         = s_q.sc_cur[7:3];
                        s_d.cmd_sectors = qdrlc_sectors({8'h00, s_q.feat_cur}, 1'b0);
                        s_d.cmd_lba     = {20'h00000, s_q.dh[3:0], s_q.ch_cur,
                                           s_q.cl_cur, s_q.sn_cur};
                        s_d.cmd_start   = 1'b1;
                    end else if (s_q.state == ST_IDLE && pwdata[7:0] == CMD_RDQ_EXT) begin
                        s_d.kind        = K_RDQX;
                        s_d.tag         = s_q.sc_cur[7:3];
                        s_d.cmd_sectors = qdrlc_sectors({s_q.feat_prev, s_q.feat_cur},
                                                        1'b1);
                        s_d.cmd_lba     = {s_q.ch_prev, s_q.cl_prev, s_q.sn_prev,
                                           s_q.ch_cur, s_q.cl_cur, s_q.sn_cur};
                        s_d.cmd_start   = 1'b1;
                    end else if (s_q.state == ST_IDLE && pwdata[7:0] == CMD_RD_LOG
                                 && !log_abort) begin
                        s_d.kind        = K_LOG;
                        s_d.state       = ST_LOG;
                        s_d.cmd_sectors = {1'b0, s_q.sn_prev, s_q.sc_cur};
                        s_d.cmd_lba     = {24'h000000, s_q.cl_prev,
                                           s_q.cl_cur, s_q.sn_cur};
                        s_d.words_left  = {s_q.sn_prev, s_q.sc_cur, 8'h00, 1'b0} >> 1;
                        s_d.word_idx    = 8'h00;
                        s_d.cmd_start   = 1'b1;
                    end else if (s_q.state == ST_REL && s_q.service_pending
                                 && pwdata[7:0] == CMD_SERVICE) begin
                        s_d.state  = ST_XFER;
                        s_d.sc_cur = {s_q.tag, 3'b010};
                    end else if (s_q.state == ST_IDLE || s_q.state == ST_REL) begin
                        s_d.err[ER_ABT] = 1'b1;
                        s_d.errf        = 1'b1;
                        s_d.intrq       = 1'b1;
                        s_d.service_pending         = 1'b0;
                        s_d.state       = ST_IDLE;
                        s_d.kind        = K_NONE;
                    end
                    if (s_d.cmd_start && s_d.kind != K_LOG) begin
                        s_d.words_left = {s_d.cmd_sectors, 8'h00};
                        if (be_data_avail) begin
                            s_d.state = ST_XFER;
                        end else begin
                            s_d.state  = ST_REL;
                            s_d.sc_cur = qdrlc_sc_report(s_d.tag, 1'b1);
                            s_d.service_pending    = 1'b0;
                            s_d.intrq  = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end

        // Readiness after a release is announced through the service flag only
        if (s_q.state == ST_REL && be_data_avail)
            s_d.service_pending = 1'b1;

        // Word drained by the DMA channel or by a data register read
        drain = (s_q.state == ST_XFER && s_q.dmarq && dma_ack)
              || (s_q.state == ST_LOG && s_q.full && rd && paddr == OFF_DATA);
        if (drain) begin
            s_d.full       = 1'b0;
            s_d.dmarq      = 1'b0;
            s_d.words_left = s_q.words_left - 25'd1;
            s_d.word_idx   = s_q.word_idx + 8'd1;
            if (s_q.words_left == 25'd1) begin
                s_d.state = ST_IDLE;
                if (s_q.state == ST_XFER) begin
                    s_d.sc_cur = qdrlc_sc_report(s_q.tag, 1'b0);
                    s_d.service_pending    = 1'b0;
                    s_d.intrq  = 1'b1;
                end
            end
        end

        // Word loaded from the back end; a new log sector raises an interrupt
        if (s_q.word_ready && be_word_valid) begin
            s_d.word  = be_word;
            s_d.full  = 1'b1;
            s_d.dmarq = s_q.state == ST_XFER;
            if (s_q.state == ST_LOG && s_q.word_idx == 8'h00)
                s_d.intrq = 1'b1;
        end

        // Unrecoverable error ends the transfer and leaves the failing address
        if (be_error && (s_q.state == ST_XFER || s_q.state == ST_LOG)) begin
            s_d.state       = ST_IDLE;
            s_d.full        = 1'b0;
            s_d.dmarq       = 1'b0;
            s_d.err[ER_UNC] = 1'b1;
            s_d.errf        = 1'b1;
            s_d.intrq       = 1'b1;
            s_d.service_pending         = 1'b0;
            if (s_q.state == ST_XFER)
                s_d.sc_cur = qdrlc_sc_report(s_q.tag, 1'b0);
            s_d.sn_cur = be_err_lba[7:0];
            s_d.cl_cur = be_err_lba[15:8];
            s_d.ch_cur = be_err_lba[23:16];
            if (s_q.kind == K_RDQ) begin
                s_d.dh[3:0] = be_err_lba[27:24];
            end else begin
                s_d.sn_prev = be_err_lba[31:24];
                s_d.cl_prev = be_err_lba[39:32];
                s_d.ch_prev = be_err_lba[47:40];
            end
        end

        // The data phase never falls back to the released state
        s_d.word_ready = (s_d.state == ST_XFER || s_d.state == ST_LOG)
                       && !s_d.full;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            s_q <= S_RESET;
        else
            s_q <= s_d;
    end

    assign prdata        = s_q.prdata;
    assign pready        = s_q.pready;
    assign pslverr       = s_q.pslverr;
    assign intrq         = s_q.intrq;
    assign dmarq         = s_q.dmarq;
    assign dma_data      = s_q.word;
    assign be_word_ready = s_q.word_ready;
    assign cmd_start     = s_q.cmd_start;
    assign cmd_kind      = s_q.kind;
    assign cmd_lba       = s_q.cmd_lba;
    assign cmd_sectors   = s_q.cmd_sectors;
    assign cmd_tag       = s_q.tag;
endmodule

// *** bench/qdrlc_cmd_assertions.sv ***
// Port-level checks for the command block
module qdrlc_cmd_assertions import qdrlc_pkg::*; (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dmarq,
    input wire logic        dma_ack,
    input wire logic [15:0] dma_data,
    input wire logic        cmd_start,
    input wire qdrlc_kind_t cmd_kind,
    input wire logic [16:0] cmd_sectors,
    input wire logic        be_error
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pready_once: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one access cycle");
    a_map_err: assert property (pready |-> pslverr == (paddr > OFF_STATE || paddr[1:0] != 2'b00))
        else $error("pslverr disagrees with address");
    a_rd_width: assert property (pready && !pwrite && paddr != OFF_DATA |-> prdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    property p_start_cause;
        cmd_start |-> $past(psel && penable && pwrite && paddr == OFF_CMD);
    endproperty
    property p_kind_ext;
        cmd_start && $past(pwdata[7:0]) == CMD_RDQ_EXT |-> cmd_kind == K_RDQX;
    endproperty
    property p_kind_short;
        cmd_start && $past(pwdata[7:0]) == CMD_RDQ |-> cmd_kind == K_RDQ;
    endproperty
    property p_count_short;
        cmd_start && cmd_kind == K_RDQ |-> cmd_sectors != 0 && cmd_sectors <= SECT_MAX8;
    endproperty
    // An unrecoverable error may withdraw the held word at once
    property p_dma_hold;
        dmarq && !dma_ack && !be_error |=> dmarq && $stable(dma_data);
    endproperty
    a_start_cause: assert property (p_start_cause)
        else $error("command start without command write");
    a_kind_ext: assert property (p_kind_ext)
        else $error("wide queued read not decoded");
    a_kind_short: assert property (p_kind_short)
        else $error("short queued read not decoded");
    a_count_short: assert property (p_count_short)
        else $error("short count out of range");
    a_dma_drop: assert property (dmarq && dma_ack |=> !dmarq)
        else $error("request stays after acknowledge");
    a_dma_hold: assert property (p_dma_hold)
        else $error("word withdrawn before acknowledge");
    c_log: cover property (cmd_start && cmd_kind == K_LOG);
    c_dma: cover property (dmarq && dma_ack);
    c_err: cover property (pready && pslverr);
endmodule
bind qdrlc_cmd qdrlc_cmd_assertions i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dmarq, .dma_ack, .dma_data, .cmd_start, .cmd_kind,
    .cmd_sectors, .be_error);

// *** bench/qdrlc_far_end.sv ***
// Back end and slave DMA channel model facing the command block
module qdrlc_far_end (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        dmarq,
    input  wire logic        be_word_ready,
    input  wire logic        avail,
    input  wire logic        slow,
    input  wire logic        fail,
    output logic             dma_ack,
    output logic             be_data_avail,
    output logic             be_word_valid,
    output logic [15:0]      be_word,
    output logic             be_error,
    output logic [47:0]      be_err_lba,
    output logic [31:0]      taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] gap_q;
    assign be_data_avail = avail;
    assign be_word_valid = presetn;
    assign be_err_lba = 48'hC3B2_A190_8776;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ack <= 1'b0;
            be_word <= 16'h0000;
            gap_q <= 2'h0;
            taken <= 32'h0;
            be_error <= 1'b0;
        end else begin
            be_error <= fail;
            gap_q <= gap_q + 2'h1;
            // Slow mode stalls the channel so the word must stand for several cycles
            dma_ack <= dmarq & ~dma_ack & (~slow | gap_q == 2'h3);
            if (dma_ack & dmarq)
                taken <= taken + 32'h1;
            if (be_word_ready)
                be_word <= be_word + 16'h1;
        end
    end
endmodule

// *** bench/queued_dma_read_log_cmds_bench.sv ***
// Self-checking bench for the queued read and log read command block
module queued_dma_read_log_cmds_bench import qdrlc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, avail = 0, slow = 0, fail = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, taken;
    logic pready, pslverr, err, intrq, dmarq, dma_ack, be_data_avail, be_word_valid;
    logic be_word_ready, be_error, cmd_start;
    logic [15:0] dma_data, be_word;
    logic [47:0] be_err_lba, cmd_lba;
    logic [16:0] cmd_sectors;
    logic [4:0]  cmd_tag;
    qdrlc_kind_t cmd_kind;
    int mismatches = 0, checked = 0, n, e;
    logic [7:0] ab [5][3] = '{'{6, 7, 1}, '{1, 7, 1}, '{3, 0, 1}, '{0, 7, 0}, '{0, 7, 2}};
    qdrlc_cmd i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .intrq, .dmarq, .dma_ack, .dma_data, .be_data_avail, .be_word_valid, .be_word,
        .be_word_ready, .be_error, .be_err_lba, .cmd_start, .cmd_kind, .cmd_lba, .cmd_sectors,
        .cmd_tag);
    qdrlc_far_end i_far (.pclk, .presetn, .dmarq, .be_word_ready, .avail, .slow, .fail, .dma_ack,
        .be_data_avail, .be_word_valid, .be_word, .be_error, .be_err_lba, .taken);
    always #5 pclk = ~pclk;
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h0, d});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [47:0] exp);
        apb(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask
    // Feature through device/head in one sweep; a second sweep makes the first the previous
    task automatic seq6(input logic [7:0] v [6]);
        for (int i = 0; i < 6; i++)
            wr(OFF_FEAT + 8'(4 * i), v[i]);
    endtask
    task automatic wait_irq;
        n = 0;
        while (intrq !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        check(intrq, 1);
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(OFF_STATE, 1);
        rdc(OFF_CTRL, CTRL_RESET);
        apb(8'h2C, 1'b0, 32'h0);
        check(err, 1);
        $display("test reset and map done");
        seq6('{8'h01, 8'h28, 8'h56, 8'h34, 8'h12, 8'h43});
        wr(OFF_CMD, CMD_RDQ);
        wait_irq();
        check(cmd_lba, 48'h0312_3456);
        rdc(OFF_SCNT, 8'h2C);
        rdc(OFF_STATE, 2);
        rdc(OFF_CMD, 8'h40);
        avail <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc(OFF_CMD, 8'h50);
        slow <= 1'b1;
        wr(OFF_CMD, CMD_SERVICE);
        e = 0;
        for (int k = 0; k < 5000 && taken < 256; k++) begin
            @(posedge pclk);
            e += (intrq === 1'b1 && taken < 256);
        end
        check(taken, 256);
        check(e, 0);
        wait_irq();
        rdc(OFF_SCNT, 8'h2B);
        rdc(OFF_CMD, 8'h40);
        slow <= 1'b0;
        $display("test release and service done");
        seq6('{8'h00, 8'h00, 8'h11, 8'h33, 8'h55, 8'hE0});
        seq6('{8'h00, 8'h48, 8'h22, 8'h44, 8'h66, 8'hE0});
        wr(OFF_CMD, CMD_RDQ_EXT);
        check(cmd_sectors, SECT_MAX16);
        check(cmd_lba, 48'h5533_1166_4422);
        check(cmd_tag, 9);
        repeat (20) @(posedge pclk);
        fail <= 1'b1;
        @(posedge pclk);
        fail <= 1'b0;
        wait_irq();
        rdc(OFF_FEAT, 8'h40);
        rdc(OFF_CMD, 8'h41);
        for (int h = 0; h < 2; h++) begin
            wr(OFF_DCTL, 8'(h << 7));
            for (int j = 0; j < 3; j++)
                rdc(OFF_SNUM + 8'(4 * j), 8'(be_err_lba >> (24 * h + 8 * j)));
        end
        wr(OFF_DCTL, 8'h00);
        $display("test wide error done");
        foreach (ab[i]) begin
            wr(OFF_CTRL, ab[i][1]);
            seq6('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0});
            seq6('{8'h00, ab[i][2], ab[i][0], 8'h00, 8'h00, 8'hE0});
            wr(OFF_CMD, CMD_RD_LOG);
            wait_irq();
            rdc(OFF_FEAT, 8'h04);
            rdc(OFF_CMD, 8'h41);
        end
        wr(OFF_CTRL, CTRL_RESET);
        $display("test log aborts done");
        seq6('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0});
        seq6('{8'h00, 8'h01, 8'h80, 8'h02, 8'h00, 8'hE0});
        wr(OFF_CMD, CMD_RD_LOG);
        check(cmd_lba, 48'h0002_80);
        check(cmd_sectors, 1);
        wait_irq();
        // The back end hands out consecutive words, the first one is already held
        e = int'(be_word) - 1;
        for (int i = 0; i < 256; i++) begin
            apb(OFF_DATA, 1'b0, 32'h0);
            check(rd, 48'(16'(e + i)));
        end
        rdc(OFF_STATE, 1);
        $display("test log read done");
        give_verdict();
    end
endmodule
